// ### rtl/scr_map.vh
`ifndef SCR_MAP_VH
`define SCR_MAP_VH
// ****************************************
// register indexes
// ****************************************
`define SCR_IDX_RATE_MIRROR   8'h14
`define SCR_IDX_UARTA_MIRROR  8'h15
`define SCR_IDX_UARTB_MIRROR  8'h16
`define SCR_IDX_FORCE_STATUS  8'h17
`define SCR_IDX_RSVD_FIRST    8'h18
`define SCR_IDX_RSVD_LAST     8'h1d
`define SCR_IDX_GAME_BASE     8'h1e
`define SCR_IDX_DRIVE_TYPE    8'h1f
`define SCR_IDX_FLOPPY_BASE   8'h20
// ****************************************
// reset values
// ****************************************
`define SCR_RST_FORCE_STATUS  8'h03
`define SCR_RST_GAME_BASE     8'h80
`define SCR_RST_DRIVE_TYPE    8'h00
`define SCR_RST_FLOPPY_BASE   8'h3c
`define SCR_RST_MIRROR        8'h00
// ****************************************
// field positions
// ****************************************
`define SCR_FRC_CHG0          0
`define SCR_FRC_CHG1          1
`define SCR_FRC_WP            2
`define SCR_GAME_MODE_OFF     2'h0
`define SCR_GAME_MODE_ONE     2'h1
`define SCR_GAME_MODE_EIGHT   2'h2
`define SCR_GAME_MODE_SIXTEEN 2'h3
`define SCR_GAME_ONE_LOW      4'h1
`endif

// ### rtl/scr_density_map.v
`timescale 1ns/1ps
// ****************************************
// density pin mapping for one drive type
// ****************************************
module scr_density_map (
   input  wire [1:0] driveType,
   input  wire       densitySelectOut,
   input  wire       rateBit0,
   input  wire       rateBit1,
   output reg        densityPin0,
   output reg        densityPin1
);
   // driveType[1] is type_bit_a, driveType[0] is type_bit_b
   always @* begin
      case (driveType)
         2'h0: begin
            densityPin0 = densitySelectOut;
            densityPin1 = rateBit0;
         end
         2'h1: begin
            densityPin0 = rateBit1;
            densityPin1 = rateBit0;
         end
         2'h2: begin
            densityPin0 = ~densitySelectOut;
            densityPin1 = rateBit0;
         end
         default: begin
            densityPin0 = rateBit0;
            densityPin1 = rateBit1;
         end
      endcase
   end
endmodule // scr_density_map

// ### rtl/scr_config_regs.v
`timescale 1ns/1ps
`include "scr_map.vh"
// Operation
// - registers reached only in configuration state with matching index loaded.
// - index 14h reads back last floppy rate-select write.
// - index 15h reads back last first-UART FIFO control write.
// - index 16h reads back last second-UART FIFO control write, same layout.
// - force status register resets to 03h; bits change0, change1, write protect.
// - force controls apply to drive pins and parallel-port floppy path.
// - force change bit set makes disk change active when drive selected.
// - writing one sets a force change bit; writing zero leaves it.
// - step with drive select clears that drive's force change bit.
// - input register bit 7 is select-and-force OR disk change pin.
// - force write protect plus any selected drive asserts write protect.
// - indexes 18h to 1Dh ignore writes and read zero.
// - game base resets 80h; bits 7..2 are address 9..4.
// - game mode bits: off, one byte 0001b, eight bytes, sixteen bytes.
// - game select needs chip select low and address bit 10 low.
// - power-good select bit overrides game select configuration.
// - drive type register resets 00h, two bits per drive, four drives.
// - density pins mapped from density and rate outputs by drive type.
// - floppy base resets 3Ch; top bits zero disables; low bits written zero.
// - floppy decode needs chip select low, address bit 10 low, 0XXXb match.
module scr_config_regs (
   input  wire       clock,
   input  wire       rst,
   input  wire       clockEnable,
   input  wire       configState,
   input  wire [7:0] configIndexRegister,
   input  wire       configDataWrite,
   input  wire       configDataRead,
   input  wire [7:0] configWriteData,
   output reg  [7:0] configReadData,
   input  wire       rateSelectWrite,
   input  wire       uartAFifoControlWrite,
   input  wire       uartBFifoControlWrite,
   input  wire [7:0] runtimeWriteData,
   input  wire       headStepSignal,
   input  wire       driveSelect0,
   input  wire       driveSelect1,
   input  wire [1:0] activeDrive,
   input  wire       diskChangeInput,
   input  wire       ppDiskChangeInput,
   input  wire       writeProtectInput,
   input  wire       ppWriteProtectInput,
   input  wire       ppFloppyActive,
   input  wire       densitySelectOut,
   input  wire       rateBit0,
   input  wire       rateBit1,
   input  wire       chipSelectLow,
   input  wire [15:0] ioAddress,
   input  wire       powerGoodFunction,
   output reg        diskChangeActive,
   output reg        writeProtectActive,
   output reg        inputRegBit7,
   output reg        gamePortSelect,
   output reg        floppySelect,
   output reg        densityPin0,
   output reg        densityPin1
);
   // ****************************************
   // register state
   // ****************************************
   reg  [7:0] rateMirror_q;
   reg  [7:0] uartAMirror_q;
   reg  [7:0] uartBMirror_q;
   reg  [2:0] forceStatus_q;
   reg  [7:0] gameBase_q;
   reg  [7:0] driveType_q;
   reg  [7:0] floppyBase_q;
   reg  [7:0] readData_d;
   wire       cfgWrite;
   wire       anySelect;
   wire       forceChange;
   wire       mapPin0;
   wire       mapPin1;
   reg  [1:0] curType;
   wire [2:0] forceStatus_d;
   wire       upperQualify;
   wire       gameHit;
   reg        gameLowHit;
   wire       floppyHit;
   wire       chipCfgAccess;

   assign chipCfgAccess = configState;
   assign cfgWrite      = chipCfgAccess & configDataWrite;

   // set wins over the step clear
   assign forceStatus_d[`SCR_FRC_CHG0] = (cfgWrite && configIndexRegister == `SCR_IDX_FORCE_STATUS
                                          && configWriteData[`SCR_FRC_CHG0])
                                       | (forceStatus_q[`SCR_FRC_CHG0]
                                          & ~(headStepSignal & driveSelect0));
   assign forceStatus_d[`SCR_FRC_CHG1] = (cfgWrite && configIndexRegister == `SCR_IDX_FORCE_STATUS
                                          && configWriteData[`SCR_FRC_CHG1])
                                       | (forceStatus_q[`SCR_FRC_CHG1]
                                          & ~(headStepSignal & driveSelect1));
   // write protect is an ordinary read/write bit
   assign forceStatus_d[`SCR_FRC_WP]   = (cfgWrite && configIndexRegister == `SCR_IDX_FORCE_STATUS) ?
                                         configWriteData[`SCR_FRC_WP] : forceStatus_q[`SCR_FRC_WP];

   // ****************************************
   // register writes
   // ****************************************
   always @(posedge clock) begin
      if (rst) begin
         rateMirror_q  <= `SCR_RST_MIRROR;
         uartAMirror_q <= `SCR_RST_MIRROR;
         uartBMirror_q <= `SCR_RST_MIRROR;
         forceStatus_q <= 3'h3;
         gameBase_q    <= `SCR_RST_GAME_BASE;
         driveType_q   <= `SCR_RST_DRIVE_TYPE;
         floppyBase_q  <= `SCR_RST_FLOPPY_BASE;
      end else if (clockEnable) begin
         if (rateSelectWrite) begin
            rateMirror_q <= runtimeWriteData;
         end
         if (uartAFifoControlWrite) begin
            uartAMirror_q <= runtimeWriteData;
         end
         if (uartBFifoControlWrite) begin
            uartBMirror_q <= runtimeWriteData;
         end
         forceStatus_q <= forceStatus_d;
         if (cfgWrite) begin
            case (configIndexRegister)
               `SCR_IDX_GAME_BASE:   gameBase_q   <= configWriteData;
               `SCR_IDX_DRIVE_TYPE:  driveType_q  <= configWriteData;
               // low bits kept zero regardless of what the host sends
               `SCR_IDX_FLOPPY_BASE: floppyBase_q <= {configWriteData[7:2], 2'h0};
               default: begin
                  // mirrors read-only, 18h-1Dh ignore writes
               end
            endcase
         end
      end
   end

   // ****************************************
   // read back
   // ****************************************
   always @* begin
      case (configIndexRegister)
         `SCR_IDX_RATE_MIRROR:  readData_d = rateMirror_q;
         `SCR_IDX_UARTA_MIRROR: readData_d = uartAMirror_q;
         `SCR_IDX_UARTB_MIRROR: readData_d = uartBMirror_q;
         `SCR_IDX_FORCE_STATUS: readData_d = {5'h00, forceStatus_q};
         `SCR_IDX_GAME_BASE:    readData_d = gameBase_q;
         `SCR_IDX_DRIVE_TYPE:   readData_d = driveType_q;
         `SCR_IDX_FLOPPY_BASE:  readData_d = floppyBase_q;
         default:               readData_d = 8'h00;
      endcase
   end

   // ****************************************
   // floppy status forcing
   // ****************************************
   assign anySelect   = driveSelect0 | driveSelect1;
   assign forceChange = (driveSelect0 & forceStatus_q[`SCR_FRC_CHG0])
                      | (driveSelect1 & forceStatus_q[`SCR_FRC_CHG1]);

   // ****************************************
   // address decoders
   // ****************************************
   assign upperQualify = ~chipSelectLow & ~ioAddress[10];

   always @* begin
      case (gameBase_q[1:0])
         `SCR_GAME_MODE_ONE:     gameLowHit = (ioAddress[3:0] == `SCR_GAME_ONE_LOW);
         `SCR_GAME_MODE_EIGHT:   gameLowHit = ~ioAddress[3];
         `SCR_GAME_MODE_SIXTEEN: gameLowHit = 1'b1;
         default:                gameLowHit = 1'b0;
      endcase
   end

   // power-good function owns the pin when selected
   assign gameHit   = upperQualify & ~powerGoodFunction & gameLowHit
                    & (ioAddress[9:4] == gameBase_q[7:2]);
   assign floppyHit = upperQualify & (floppyBase_q[7:6] != 2'h0) & ~ioAddress[3]
                    & (ioAddress[9:4] == floppyBase_q[7:2]);

   // ****************************************
   // density pin mapping
   // ****************************************
   always @* begin
      case (activeDrive)
         2'h0:    curType = {driveType_q[1], driveType_q[0]};
         2'h1:    curType = {driveType_q[3], driveType_q[2]};
         2'h2:    curType = {driveType_q[5], driveType_q[4]};
         default: curType = {driveType_q[7], driveType_q[6]};
      endcase
   end

   scr_density_map densityMap (
      .driveType        (curType),
      .densitySelectOut (densitySelectOut),
      .rateBit0         (rateBit0),
      .rateBit1         (rateBit1),
      .densityPin0      (mapPin0),
      .densityPin1      (mapPin1)
   );

   // ****************************************
   // registered outputs
   // ****************************************
   always @(posedge clock) begin
      if (rst) begin
         configReadData     <= 8'h00;
         diskChangeActive   <= 1'b0;
         writeProtectActive <= 1'b0;
         inputRegBit7       <= 1'b0;
         gamePortSelect     <= 1'b0;
         floppySelect       <= 1'b0;
         densityPin0        <= 1'b0;
         densityPin1        <= 1'b0;
      end else if (clockEnable) begin
         configReadData     <= (chipCfgAccess & configDataRead) ? readData_d : 8'h00;
         // parallel-port path picks its own pins, forcing applies alike
         diskChangeActive   <= forceChange | (ppFloppyActive ? ppDiskChangeInput : diskChangeInput);
         writeProtectActive <= (forceStatus_q[`SCR_FRC_WP] & anySelect)
                             | (ppFloppyActive ? ppWriteProtectInput : writeProtectInput);
         inputRegBit7       <= forceChange | (ppFloppyActive ? ppDiskChangeInput : diskChangeInput);
         gamePortSelect     <= gameHit;
         floppySelect       <= floppyHit;
         densityPin0        <= mapPin0;
         densityPin1        <= mapPin1;
      end
   end
endmodule // scr_config_regs

// ### bench/scr_host_model.sv
`timescale 1ns/1ps
// *******
// host side of the index/data ports
// *******
module scr_host_model (
   input  wire        clock,
   input  wire  [7:0] configReadData,
   output logic       configState,
   output logic [7:0] configIndexRegister,
   output logic       configDataWrite,
   output logic       configDataRead,
   output logic [7:0] configWriteData
);
   logic inCfg = 1;
   initial begin
      configState = 0;
      configIndexRegister = 0;
      configDataWrite = 0;
      configDataRead = 0;
      configWriteData = 0;
   end
   task wr(input [7:0] i, input [7:0] d);
      @(posedge clock);
      configState <= inCfg;
      configDataRead <= 1'b0;
      configIndexRegister <= i;
      configWriteData <= d;
      configDataWrite <= 1'b1;
      @(posedge clock);
      configDataWrite <= 1'b0;
      // released data must not look like a held value
      configWriteData <= ~d;
   endtask
   task rd(input [7:0] i, output [7:0] d);
      @(posedge clock);
      configState <= inCfg;
      configIndexRegister <= i;
      configDataRead <= 1'b1;
      @(posedge clock);
      #1 d = configReadData;
   endtask
endmodule // scr_host_model

// ### bench/scr_config_regs_checker.sv
`timescale 1ns/1ps
// *******
// port checks
// *******
module scr_config_regs_checker (
   input wire        clock,
   input wire        rst,
   input wire        clockEnable,
   input wire        configState,
   input wire  [7:0] configIndexRegister,
   input wire        configDataRead,
   input wire  [7:0] configReadData,
   input wire        diskChangeInput,
   input wire        ppDiskChangeInput,
   input wire        writeProtectInput,
   input wire        ppWriteProtectInput,
   input wire        ppFloppyActive,
   input wire        driveSelect0,
   input wire        driveSelect1,
   input wire        chipSelectLow,
   input wire [15:0] ioAddress,
   input wire        powerGoodFunction,
   input wire        diskChangeActive,
   input wire        writeProtectActive,
   input wire        inputRegBit7,
   input wire        gamePortSelect,
   input wire        floppySelect
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire sel = driveSelect0 | driveSelect1;
   wire rdOn = clockEnable & configState & configDataRead;
   wire rsv = configIndexRegister >= 8'h18 && configIndexRegister <= 8'h1d;
   a_read_idle_zero: assert property ($past(!rdOn & clockEnable) |-> configReadData == 8'h00)
      else $error("read data not zero while idle");
   a_reserved_read_zero: assert property ($past(rdOn & rsv) |-> configReadData == 8'h00)
      else $error("reserved index read not zero");
   a_game_qualify: assert property (gamePortSelect |-> $past(!chipSelectLow & !ioAddress[10] & !powerGoodFunction))
      else $error("game select without qualifiers");
   a_floppy_qualify: assert property (floppySelect |-> $past(!chipSelectLow & !ioAddress[10] & !ioAddress[3]))
      else $error("floppy select without qualifiers");
   a_protect_cause: assert property (writeProtectActive |-> $past(writeProtectInput | ppWriteProtectInput | sel))
      else $error("write protect without cause");
   a_change_cause: assert property (diskChangeActive |-> $past(diskChangeInput | ppDiskChangeInput | sel))
      else $error("disk change without cause");
   a_bit7_cause: assert property (inputRegBit7 |-> $past(diskChangeInput | ppDiskChangeInput | sel))
      else $error("input bit 7 without cause");
   a_pin_to_bit7: assert property ($past(!rst & clockEnable & diskChangeInput & !ppFloppyActive) |-> inputRegBit7)
      else $error("disk change pin not seen in bit 7");
endmodule // scr_config_regs_checker
bind scr_config_regs scr_config_regs_checker chk (.*);

// ### bench/scr_config_regs_bench.sv
`timescale 1ns/1ps
module scr_config_regs_bench;
   logic clock = 0, rst = 1, clockEnable = 1, rateSelectWrite = 0, uartAFifoControlWrite = 0;
   logic uartBFifoControlWrite = 0, headStepSignal = 0, driveSelect0 = 0, driveSelect1 = 0;
   logic diskChangeInput = 0, ppDiskChangeInput = 0, writeProtectInput = 0, ppWriteProtectInput = 0;
   logic ppFloppyActive = 0, densitySelectOut = 0, rateBit0 = 0, rateBit1 = 0, chipSelectLow = 1;
   logic powerGoodFunction = 0, configState, configDataWrite, configDataRead, densityPin0, densityPin1;
   logic diskChangeActive, writeProtectActive, inputRegBit7, gamePortSelect, floppySelect;
   logic [1:0] activeDrive = 0, e;
   logic [7:0] runtimeWriteData = 0, configIndexRegister, configWriteData, configReadData, v;
   logic [15:0] ioAddress = 0;
   int failures = 0, compares = 0;
   always #20 clock = ~clock;
   scr_config_regs DUT (.*);
   scr_host_model host (.*);
   task chk(input [7:0] seen, input [7:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task cyc(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task rc(input [7:0] i, input [7:0] x);
      host.rd(i, v);
      chk(v, x);
   endtask
   task io(input [15:0] a);
      @(posedge clock) ioAddress <= a;
      cyc(1);
   endtask
   task rt(input [7:0] k, input [7:0] d);
      @(posedge clock) runtimeWriteData <= d;
      {rateSelectWrite, uartAFifoControlWrite, uartBFifoControlWrite} <= 3'b100 >> k;
      @(posedge clock) {rateSelectWrite, uartAFifoControlWrite, uartBFifoControlWrite} <= 3'h0;
   endtask
   task t_regs;
      rc(8'h17, 8'h03);
      rc(8'h1e, 8'h80);
      rc(8'h1f, 8'h00);
      rc(8'h20, 8'h3c);
      for (logic [7:0] k = 0; k < 3; k++) begin
         rt(k, 8'h11);
         rt(k, 8'hc9 + k);
         host.wr(8'h14 + k, 8'h5a);
         rc(8'h14 + k, 8'hc9 + k);
      end
      for (logic [7:0] i = 8'h18; i < 8'h1e; i++) begin
         host.wr(i, 8'hff);
         rc(i, 8'h00);
      end
      host.inCfg = 0;
      host.wr(8'h1e, 8'h55);
      host.inCfg = 1;
      rc(8'h1e, 8'h80);
   endtask
   task t_force;
      host.wr(8'h17, 8'h00);
      rc(8'h17, 8'h03);
      @(posedge clock) driveSelect1 <= 1;
      cyc(1);
      chk(inputRegBit7, 1);
      chk(diskChangeActive, 1);
      @(posedge clock) headStepSignal <= 1;
      @(posedge clock) headStepSignal <= 0;
      cyc(1);
      chk(inputRegBit7, 0);
      host.wr(8'h17, 8'h04);
      rc(8'h17, 8'h05);
      chk(writeProtectActive, 1);
      @(posedge clock) ppFloppyActive <= 1;
      cyc(1);
      chk(writeProtectActive, 1);
      @(posedge clock) {ppFloppyActive, driveSelect1} <= 2'h0;
      cyc(1);
      chk(writeProtectActive, 0);
      @(posedge clock) diskChangeInput <= 1;
      cyc(1);
      chk(inputRegBit7, 1);
      @(posedge clock) diskChangeInput <= 0;
   endtask
   task t_decode;
      @(posedge clock) chipSelectLow <= 0;
      for (logic [2:0] m = 0; m < 4; m++) begin
         host.wr(8'h1e, 8'h80 | m[1:0]);
         io(16'h0201);
         chk(gamePortSelect, m != 0);
         io(16'h0209);
         chk(gamePortSelect, m == 3);
         io(16'h0207);
         chk(gamePortSelect, m[1]);
      end
      io(16'h0601);
      chk(gamePortSelect, 0);
      @(posedge clock) powerGoodFunction <= 1;
      io(16'h0201);
      chk(gamePortSelect, 0);
      io(16'h00f5);
      chk(floppySelect, 0);
      host.wr(8'h20, 8'hfc);
      io(16'h03f5);
      chk(floppySelect, 1);
      io(16'h03f8);
      chk(floppySelect, 0);
      @(posedge clock) chipSelectLow <= 1;
      io(16'h03f1);
      chk(floppySelect, 0);
   endtask
   task t_enable;
      // a write while the enable is low must leave the game base untouched
      @(posedge clock) clockEnable <= 0;
      host.wr(8'h1e, 8'h44);
      @(posedge clock) clockEnable <= 1;
      rc(8'h1e, 8'h83);
   endtask
   task t_density;
      @(posedge clock) activeDrive <= 2'h3;
      for (logic [5:0] s = 0; s < 32; s++) begin
         @(posedge clock) {densitySelectOut, rateBit0, rateBit1} <= s[2:0];
         host.wr(8'h1f, {s[4:3], 6'h00});
         cyc(1);
         case (s[4:3])
            2'h0: e = {s[2], s[1]};
            2'h1: e = {s[0], s[1]};
            2'h2: e = {~s[2], s[1]};
            default: e = {s[1], s[0]};
         endcase
         chk({densityPin0, densityPin1}, e);
      end
   endtask
   initial begin
      repeat (2) @(posedge clock);
      rst <= 0;
      t_regs;
      t_force;
      t_decode;
      t_enable;
      t_density;
      conclude;
   end
   // run cut short if the sequence ever hangs
   initial begin
      #3000000;
      failures++;
      conclude;
   end
endmodule // scr_config_regs_bench
